// ### design/shp_pkg.sv
package shp_pkg;
    // timing
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned POR_TIME_MS = 40;
    localparam int unsigned POR_CYCLES = POR_TIME_MS * CLK_MHZ * 1000;
    localparam int unsigned EXEC_TIME_NS = 63000;
    localparam int unsigned EXEC_CYCLES = (EXEC_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned TMR_W = 24;
    // display data memory
    localparam int unsigned DD_DEPTH = 40;
    localparam int unsigned AC_W = 6;
    localparam logic [AC_W-1:0] AC_FIRST = 6'h00;
    localparam logic [AC_W-1:0] AC_LAST = 6'h27;
    localparam logic [AC_W-1:0] AC_ONE = 6'h01;
    localparam logic [7:0] SPACE_CODE = 8'h20;
    // serial framing
    localparam logic [2:0] SYNC_LAST = 3'h4;
    localparam logic [1:0] HDR_RW = 2'h0;
    localparam logic [1:0] HDR_RS = 2'h1;
    localparam logic [1:0] HDR_ZERO = 2'h2;
    localparam logic [3:0] BIT_LAST = 4'hF;
    localparam int unsigned NIB_W = 4;
    localparam int unsigned LO_NIB_POS = 0;
    localparam int unsigned HI_NIB_POS = 8;
    // key scan latches
    localparam int unsigned NUM_LATCH = 6;
    localparam int unsigned LATCH_W = 5;
    localparam logic [2:0] LATCH_FIRST = 3'h0;
    localparam logic [2:0] LATCH_LAST = 3'h5;
    localparam logic [2:0] LATCH_ONE = 3'h1;

    typedef logic [NUM_LATCH-1:0][LATCH_W-1:0] shp_keys_t;

    typedef struct packed {
        logic irq_enable;
        logic sleep_select;
        logic ext_reg_write_enable;
        logic [1:0] scan_cycle_field;
        logic char_mem_blink_enable;
        logic low_power_select;
        logic display_on;
        logic cursor_on;
        logic blink_on;
        logic inc_dec;
        logic entry_shift;
        logic font_reverse;
        logic cursor_style;
        logic [1:0] hscroll_line_enable;
        logic [1:0] led_out;
        logic [4:0] dot_scroll_amount;
    } shp_cfg_t;

    localparam shp_cfg_t CFG_RESET = '{
        irq_enable: 1'h0,
        sleep_select: 1'h0,
        ext_reg_write_enable: 1'h0,
        scan_cycle_field: 2'h0,
        char_mem_blink_enable: 1'h0,
        low_power_select: 1'h0,
        display_on: 1'h0,
        cursor_on: 1'h0,
        blink_on: 1'h0,
        inc_dec: 1'h1,
        entry_shift: 1'h0,
        font_reverse: 1'h0,
        cursor_style: 1'h0,
        hscroll_line_enable: 2'h0,
        led_out: 2'h3,
        dot_scroll_amount: 5'h00
    };

    typedef enum logic [2:0] {
        IN_CLEAR = 3'b001,
        IN_WAIT = 3'b010,
        IN_READY = 3'b100
    } shp_init_t;

    typedef enum logic [2:0] {
        LK_HUNT = 3'b001,
        LK_HDR = 3'b010,
        LK_DATA = 3'b100
    } shp_link_t;
endpackage : shp_pkg

// ### design/shp_top.sv
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - busy held through power-on initialisation time
// - initialisation fills display memory with spaces
// - clear irq, sleep, ext write, scan, blink, lowpower
// - display off, increment by one, no shift
// - no reverse, normal cursor, no scroll, leds high
// - dot scroll amount cleared to zero
// - hardware reset reinitialises but keeps scan cycle
// - hardware reset ignored during power-on initialisation
// - serial clock honoured only while selected
// - deselect clears bit counter and partial data
// - start byte: five ones, direction, select, zero
// - write words arrive as two nibble bytes
// - read words leave in same nibble format
// - select-zero reads rotate through six key latches
// - sync string watched while transmitting
// - unchanged direction/select allows back-to-back words
// - run on last bit; drop words while busy
// - early reads give invalid data
// - serial clock independent; no instruction queue
// - address steps by one as busy clears
// - status word: busy, scan state, scan bits
// - key latch data sent least significant first
module shp_top #(
    parameter int unsigned POR_CYCLES_P = shp_pkg::POR_CYCLES,
    parameter int unsigned EXEC_CYCLES_P = shp_pkg::EXEC_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_in,
    input wire logic hw_reset_n,
    input wire shp_pkg::shp_keys_t key_latches,
    input wire logic [1:0] scan_state,
    input wire logic cfg_wr,
    input wire shp_pkg::shp_cfg_t cfg_wdata,
    output logic serial_out,
    output logic busy_flag,
    output logic instr_valid,
    output logic [7:0] instr_data,
    output shp_pkg::shp_cfg_t cfg,
    output logic [shp_pkg::AC_W-1:0] addr_counter
);
    import shp_pkg::*;

    localparam logic [TMR_W-1:0] TMR_ZERO = 24'h000000;
    localparam logic [TMR_W-1:0] TMR_ONE = 24'h000001;
    localparam logic [TMR_W-1:0] POR_LAST = TMR_W'(POR_CYCLES_P - 1);
    localparam logic [TMR_W-1:0] EXEC_LOAD = TMR_W'(EXEC_CYCLES_P);

    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_d;
        logic cs_s1;
        logic cs_s2;
        logic sid_s1;
        logic sid_s2;
        logic hrst_s1;
        logic hrst_s2;
        shp_init_t init;
        logic [TMR_W-1:0] tmr;
        logic [AC_W-1:0] clr_idx;
        logic [TMR_W-1:0] exec_tmr;
        logic step_pend;
        shp_link_t link;
        logic [2:0] ones;
        logic [1:0] hdr_idx;
        logic rw;
        logic rs;
        logic [3:0] bitcnt;
        logic [15:0] rx;
        logic [7:0] tx;
        logic [2:0] latch_idx;
        logic sout;
        logic instr_v;
        logic [7:0] instr_d;
        shp_cfg_t cfg;
        logic [AC_W-1:0] ac;
        logic [DD_DEPTH-1:0][7:0] display_data_mem;
    } shp_state_t;

    localparam shp_state_t ST_RST = '{
        cs_s1: 1'h1,
        cs_s2: 1'h1,
        hrst_s1: 1'h1,
        hrst_s2: 1'h1,
        init: IN_CLEAR,
        link: LK_HUNT,
        cfg: CFG_RESET,
        default: '0
    };

    shp_state_t st_r;
    shp_state_t st_nxt;
    logic rise;
    logic fall;
    logic sel;
    logic sbit;
    logic busy;
    logic [AC_W-1:0] ac_step;
    logic [7:0] rx_word;
    logic tx_bit;

    // edges found on the synchronised copy; first stage feeds nothing else
    assign rise = st_r.sclk_s2 & ~st_r.sclk_d;
    assign fall = ~st_r.sclk_s2 & st_r.sclk_d;
    assign sel = ~st_r.cs_s2;
    assign sbit = st_r.sid_s2;
    // the one-cycle address step counts as busy so no access races it
    assign busy = (st_r.init != IN_READY) | (st_r.exec_tmr != TMR_ZERO) | st_r.step_pend;
    assign rx_word = {st_r.rx[HI_NIB_POS +: NIB_W], st_r.rx[LO_NIB_POS +: NIB_W]};
    // bits 4..7 of each byte are zero padding
    assign tx_bit = st_r.bitcnt[2] ? 1'b0 : st_r.tx[{st_r.bitcnt[3], st_r.bitcnt[1:0]}];

    always_comb begin
        if (st_r.cfg.inc_dec) begin
            ac_step = (st_r.ac == AC_LAST) ? AC_FIRST : st_r.ac + AC_ONE;
        end else begin
            ac_step = (st_r.ac == AC_FIRST) ? AC_LAST : st_r.ac - AC_ONE;
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.instr_v = 1'b0;
        st_nxt.sclk_s1 = sclk;
        st_nxt.sclk_s2 = st_r.sclk_s1;
        st_nxt.sclk_d = st_r.sclk_s2;
        st_nxt.cs_s1 = cs_n;
        st_nxt.cs_s2 = st_r.cs_s1;
        st_nxt.sid_s1 = serial_in;
        st_nxt.sid_s2 = st_r.sid_s1;
        st_nxt.hrst_s1 = hw_reset_n;
        st_nxt.hrst_s2 = st_r.hrst_s1;

        // execution timer, then the deferred address step
        if (st_r.exec_tmr != TMR_ZERO) begin
            st_nxt.exec_tmr = st_r.exec_tmr - TMR_ONE;
        end else if (st_r.step_pend) begin
            st_nxt.step_pend = 1'b0;
            st_nxt.ac = ac_step;
        end

        if (!sel) begin
            // deselect drops any half-received word
            st_nxt.link = LK_HUNT;
            st_nxt.ones = 3'h0;
            st_nxt.bitcnt = 4'h0;
            st_nxt.hdr_idx = HDR_RW;
            st_nxt.sout = 1'b0;
        end else begin
            if (rise) begin
                if (!sbit) begin
                    st_nxt.ones = 3'h0;
                end else if (st_r.ones != SYNC_LAST) begin
                    st_nxt.ones = st_r.ones + 3'h1;
                end
                // sync is watched in every state but the header itself
                if (sbit && st_r.ones == SYNC_LAST && st_r.link != LK_HDR) begin
                    st_nxt.link = LK_HDR;
                    st_nxt.hdr_idx = HDR_RW;
                end else begin
                    unique case (st_r.link)
                        LK_HUNT: begin
                            st_nxt.bitcnt = 4'h0;
                        end
                        LK_HDR: begin
                            st_nxt.hdr_idx = st_r.hdr_idx + 2'h1;
                            if (st_r.hdr_idx == HDR_RW) begin
                                st_nxt.rw = sbit;
                            end else if (st_r.hdr_idx == HDR_RS) begin
                                st_nxt.rs = sbit;
                            end else if (sbit) begin
                                // a one in the last header bit is a broken frame
                                st_nxt.link = LK_HUNT;
                            end else begin
                                st_nxt.link = LK_DATA;
                                st_nxt.bitcnt = 4'h0;
                                st_nxt.latch_idx = LATCH_FIRST;
                                if (st_r.rw) begin
                                    if (st_r.rs) begin
                                        st_nxt.tx = st_r.display_data_mem[st_r.ac];
                                        st_nxt.exec_tmr = EXEC_LOAD;
                                        st_nxt.step_pend = 1'b1;
                                    end else begin
                                        st_nxt.tx = {busy, scan_state,
                                            key_latches[LATCH_FIRST]};
                                        st_nxt.latch_idx = LATCH_ONE;
                                    end
                                end
                            end
                        end
                        LK_DATA: begin
                            st_nxt.rx[st_r.bitcnt] = sbit;
                            st_nxt.bitcnt = st_r.bitcnt + 4'h1;
                            if (st_r.bitcnt == BIT_LAST) begin
                                // word complete; stay in data for the next one
                                if (!st_r.rw) begin
                                    if (!busy) begin
                                        st_nxt.exec_tmr = EXEC_LOAD;
                                        if (st_r.rs) begin
                                            st_nxt.display_data_mem[st_r.ac] = rx_word;
                                            st_nxt.step_pend = 1'b1;
                                        end else begin
                                            st_nxt.instr_v = 1'b1;
                                            st_nxt.instr_d = rx_word;
                                        end
                                    end
                                end else if (st_r.rs) begin
                                    // no wait check here: an early read is stale
                                    st_nxt.tx = st_r.display_data_mem[st_r.ac];
                                    st_nxt.exec_tmr = EXEC_LOAD;
                                    st_nxt.step_pend = 1'b1;
                                end else begin
                                    st_nxt.tx = {busy, scan_state,
                                        key_latches[st_r.latch_idx]};
                                    st_nxt.latch_idx = (st_r.latch_idx == LATCH_LAST) ?
                                        LATCH_FIRST : st_r.latch_idx + LATCH_ONE;
                                end
                            end
                        end
                    endcase
                end
            end
            if (fall) begin
                // scan bits sit in the low bits, so they go out lsb first
                st_nxt.sout = (st_r.link == LK_DATA && st_r.rw) ? tx_bit : 1'b0;
            end
        end

        // initialisation runs last so a hardware reset overrides the address, timer and step of an access in the same cycle
        unique case (st_r.init)
            IN_CLEAR: begin
                st_nxt.display_data_mem[st_r.clr_idx] = SPACE_CODE;
                if (st_r.clr_idx == AC_LAST) begin
                    st_nxt.init = IN_WAIT;
                    st_nxt.tmr = TMR_ZERO;
                end else begin
                    st_nxt.clr_idx = st_r.clr_idx + AC_ONE;
                end
            end
            IN_WAIT: begin
                st_nxt.tmr = st_r.tmr + TMR_ONE;
                if (st_r.tmr == POR_LAST) begin
                    st_nxt.init = IN_READY;
                end
            end
            IN_READY: begin
                // the pin is only looked at once initialisation is done
                if (!st_r.hrst_s2) begin
                    st_nxt.init = IN_CLEAR;
                    st_nxt.clr_idx = AC_FIRST;
                    st_nxt.cfg = CFG_RESET;
                    st_nxt.cfg.scan_cycle_field = st_r.cfg.scan_cycle_field;
                    st_nxt.ac = AC_FIRST;
                    st_nxt.exec_tmr = TMR_ZERO;
                    st_nxt.step_pend = 1'b0;
                end else if (cfg_wr) begin
                    st_nxt.cfg = cfg_wdata;
                end
            end
        endcase
    end

    // power-on values come from ST_RST, including the cleared settings
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign serial_out = st_r.sout;
    assign busy_flag = busy;
    assign instr_valid = st_r.instr_v;
    assign instr_data = st_r.instr_d;
    assign cfg = st_r.cfg;
    assign addr_counter = st_r.ac;
endmodule : shp_top

`default_nettype wire

// ### testbench/shp_sva.sv
`timescale 1ns/1ns
`default_nettype none
module shp_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_in,
    input wire logic hw_reset_n,
    input wire shp_pkg::shp_keys_t key_latches,
    input wire logic [1:0] scan_state,
    input wire logic cfg_wr,
    input wire shp_pkg::shp_cfg_t cfg_wdata,
    input wire logic serial_out,
    input wire logic busy_flag,
    input wire logic instr_valid,
    input wire logic [7:0] instr_data,
    input wire shp_pkg::shp_cfg_t cfg,
    input wire logic [shp_pkg::AC_W-1:0] addr_counter
);
    import shp_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // four cycles covers the select synchroniser
    sequence s_deselected;
        cs_n [*4];
    endsequence
    sequence s_hw_pulse;
        (!hw_reset_n && !busy_flag) ##1 !hw_reset_n [*2];
    endsequence
    a_reset_defaults: assert property ($fell(rst) |-> busy_flag && cfg == CFG_RESET
        && addr_counter == AC_FIRST && !serial_out) else $error("reset values wrong");
    a_init_busy: assert property ($fell(rst) |-> busy_flag [*8])
        else $error("busy low during init");
    a_instr_busy: assert property (instr_valid |=> busy_flag)
        else $error("no busy after instruction");
    a_instr_single: assert property (instr_valid |=> !instr_valid)
        else $error("instruction pulse too long");
    a_desel_quiet: assert property (s_deselected |-> !instr_valid)
        else $error("instruction while deselected");
    a_desel_out: assert property (s_deselected |-> !serial_out)
        else $error("output active while deselected");
    a_hw_reinit: assert property (s_hw_pulse |-> ##[0:4] (busy_flag && addr_counter == AC_FIRST))
        else $error("hardware reset not honoured");
    a_scan_kept: assert property (!cfg_wr |=> $stable(cfg.scan_cycle_field))
        else $error("scan cycle field changed");
    a_addr_range: assert property (addr_counter <= AC_LAST)
        else $error("address counter out of range");
endmodule : shp_sva
`default_nettype wire

// ### testbench/shp_host.sv
`timescale 1ns/1ns
`default_nettype none
module shp_host (
    input wire logic clock,
    input wire logic serial_out,
    output logic sclk,
    output logic cs_n,
    output logic serial_in
);
    // clock stands high between frames; 128 ns period, nearest to 125 on clock edges
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        serial_in = 1'b0;
    end
    task automatic bit_io(input logic b, output logic r);
        @(negedge clock);
        sclk = 1'b0;
        serial_in = b;
        repeat (8) @(negedge clock);
        r = serial_out;
        sclk = 1'b1;
        repeat (7) @(negedge clock);
    endtask : bit_io
    task automatic send(input logic [7:0] v, input int n, output logic [7:0] r);
        r = 8'h00;
        for (int i = 0; i < n; i++) bit_io(v[i], r[i]);
    endtask : send
    task automatic start(input logic rw, input logic rs);
        logic [7:0] r;
        @(negedge clock);
        cs_n = 1'b0;
        send({1'b0, rs, rw, 5'h1F}, 8, r);
    endtask : start
    task automatic word(input logic [7:0] w, output logic [7:0] r);
        logic [7:0] a;
        logic [7:0] b;
        send({4'h0, w[3:0]}, 8, a);
        send({4'h0, w[7:4]}, 8, b);
        r = {b[3:0], a[3:0]};
    endtask : word
    task automatic stop; // released line shows the inverse of its last value
        @(negedge clock);
        cs_n = 1'b1;
        serial_in = ~serial_in;
        repeat (8) @(negedge clock);
    endtask : stop
endmodule : shp_host
`default_nettype wire

// ### testbench/shp_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module shp_top_tb_top;
    import shp_pkg::*;
    localparam int POR = 200;
    localparam int EXEC = 300;
    localparam int INIT = 40 + POR;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hw_reset_n = 1'b1;
    logic cfg_wr = 1'b0;
    logic [1:0] scan_state = 2'h2;
    shp_cfg_t cfg_wdata = CFG_RESET;
    shp_keys_t key_latches = {5'h16, 5'h15, 5'h04, 5'h13, 5'h0A, 5'h11};
    logic sclk, cs_n, serial_in, serial_out, busy_flag, instr_valid;
    logic [7:0] instr_data;
    shp_cfg_t cfg;
    logic [AC_W-1:0] addr_counter;
    int n_errors = 0;
    int compares = 0;
    int n_instr = 0;
    int cyc = 0;
    shp_top #(.POR_CYCLES_P(POR), .EXEC_CYCLES_P(EXEC)) i_shp_top (.clock, .rst, .sclk,
        .cs_n, .serial_in, .hw_reset_n, .key_latches, .scan_state, .cfg_wr, .cfg_wdata,
        .serial_out, .busy_flag, .instr_valid, .instr_data, .cfg, .addr_counter);
    shp_host i_shp_host (.clock, .serial_out, .sclk, .cs_n, .serial_in);
    always #4 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (instr_valid === 1'b1) n_instr++;
        if (cyc == 40000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic finish_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task automatic cfg_load(input shp_cfg_t v);
        cfg_wdata = v;
        cfg_wr = 1'b1;
        @(negedge clock);
        cfg_wr = 1'b0;
        @(negedge clock);
    endtask : cfg_load
    task automatic t_por;
        check("cfg", cfg, CFG_RESET);
        check("ac", addr_counter, AC_FIRST);
        repeat (100) @(negedge clock);
        hw_reset_n = 1'b0;
        repeat (4) @(negedge clock);
        hw_reset_n = 1'b1;
        repeat (INIT - 108) @(negedge clock);
        check("busy", busy_flag, 1'b1);
        repeat (12) @(negedge clock);
        check("busy", busy_flag, 1'b0);
    endtask : t_por
    task automatic t_scan;
        logic [7:0] r;
        i_shp_host.start(1'b1, 1'b0);
        for (int k = 0; k < 7; k++) begin
            i_shp_host.word(8'h00, r);
            check("scan", r, {1'b0, scan_state, key_latches[k % 6]});
        end
        i_shp_host.start(1'b0, 1'b0);
        i_shp_host.word(8'h77, r);
        check("resync", instr_data, 8'h77);
        i_shp_host.stop();
        repeat (EXEC) @(negedge clock);
    endtask : t_scan
    task automatic t_instr;
        logic [7:0] r;
        int n0;
        n0 = n_instr;
        i_shp_host.start(1'b0, 1'b0);
        i_shp_host.word(8'hA5, r);
        check("instr", instr_data, 8'hA5);
        i_shp_host.word(8'h3C, r);
        check("dropped", n_instr - n0, 1);
        i_shp_host.word(8'hC3, r);
        check("instr", instr_data, 8'hC3);
        check("count", n_instr - n0, 2);
        i_shp_host.stop();
        repeat (EXEC) @(negedge clock);
        n0 = n_instr;
        i_shp_host.start(1'b0, 1'b0);
        i_shp_host.send(8'h0F, 8, r);
        i_shp_host.stop();
        i_shp_host.start(1'b0, 1'b0);
        i_shp_host.word(8'h5A, r);
        check("restart", instr_data, 8'h5A);
        i_shp_host.stop();
        repeat (EXEC) @(negedge clock);
        i_shp_host.send(8'h1F, 8, r);
        i_shp_host.send(8'h01, 8, r);
        i_shp_host.send(8'h02, 8, r);
        check("count", n_instr - n0, 1);
    endtask : t_instr
    task automatic mem_rw(input logic rw, input logic [7:0] v, input logic [5:0] ac);
        logic [7:0] r;
        i_shp_host.start(rw, 1'b1);
        repeat (EXEC) @(negedge clock); // read period before data
        i_shp_host.word(v, r);
        i_shp_host.stop();
        repeat (EXEC + 10) @(negedge clock);
        if (rw) check("mem", r, v);
        check("ac", addr_counter, ac);
    endtask : mem_rw
    task automatic t_mem;
        shp_cfg_t c;
        c = CFG_RESET;
        c.inc_dec = 1'b0;
        // a read frame fetches at the header and again after each word, so ac steps twice
        mem_rw(1'b1, SPACE_CODE, 6'h02);
        mem_rw(1'b0, 8'h41, 6'h03);
        cfg_load(c);
        mem_rw(1'b0, 8'h42, 6'h02);
        mem_rw(1'b1, 8'h41, 6'h00);
        mem_rw(1'b1, SPACE_CODE, 6'h26);
    endtask : t_mem
    task automatic t_hwrst;
        shp_cfg_t e;
        e = CFG_RESET;
        e.scan_cycle_field = 2'h3;
        cfg_load('1);
        check("cfg", cfg, cfg_wdata);
        hw_reset_n = 1'b0;
        repeat (4) @(negedge clock);
        hw_reset_n = 1'b1;
        repeat (6) @(negedge clock);
        check("busy", busy_flag, 1'b1);
        check("ac", addr_counter, AC_FIRST);
        check("cfg", cfg, e);
        repeat (INIT + 10) @(negedge clock);
        check("busy", busy_flag, 1'b0);
    endtask : t_hwrst
    initial begin
        repeat (6) @(negedge clock);
        rst = 1'b0;
        t_por();
        t_scan();
        t_instr();
        t_mem();
        t_hwrst();
        finish_test();
    end
endmodule : shp_top_tb_top
bind shp_top shp_sva i_shp_sva (.clock, .rst, .sclk, .cs_n, .serial_in, .hw_reset_n,
    .key_latches, .scan_state, .cfg_wr, .cfg_wdata, .serial_out, .busy_flag, .instr_valid,
    .instr_data, .cfg, .addr_counter);
`default_nettype wire
